// ===== upcd_demo_regs.svh
`ifndef UPCD_DEMO_REGS_SVH
`define UPCD_DEMO_REGS_SVH

// User clock rate
`define UPCD_CLK_HZ        100000000
// Time each chase lamp stays lit, in milliseconds
`define UPCD_STEP_MS       100
// Lamp step in clock cycles, derived from the two figures above
`define UPCD_STEP_CYCLES   (`UPCD_STEP_MS * (`UPCD_CLK_HZ / 1000))
// Width of the step counter, wide enough for the default step
`define UPCD_STEP_CNT_W    24

// Chase lamp layout: bit 6 is D9, bit 0 is D3
`define UPCD_LAMP_N        7
`define UPCD_LAMP_RST      7'h40
`define UPCD_ERR_RST       1'h0

// Switch positions within switchInputs
`define UPCD_SW_ENABLE     0
`define UPCD_SW_START      1

`endif

// ===== upcd_pkg.sv
package upcd_pkg;

   typedef enum logic [1:0] {
      UPCD_IDLE   = 2'b00,
      UPCD_LAUNCH = 2'b01,
      UPCD_WAIT   = 2'b10
   } upcd_state_e;

   // Towards the hard checker
   typedef struct packed {
      logic enable;
      logic start;
   } upcd_chk_req_s;

   // From the hard checker
   typedef struct packed {
      logic done;
      logic err;
   } upcd_chk_rsp_s;

endpackage

// ===== upcd_chase.sv
`timescale 1ns/1ps
`include "upcd_demo_regs.svh"

module upcd_chase #(
   parameter int unsigned STEP_CYCLES = `UPCD_STEP_CYCLES
) (
   input  wire logic                     clk,
   input  wire logic                     rstN,
   input  wire logic                     clkEn,
   output logic [`UPCD_LAMP_N-1:0]       lamps
);

   localparam int CNT_W = `UPCD_STEP_CNT_W;

   logic [CNT_W-1:0]         stepCnt_ff;
   logic [CNT_W-1:0]         nxt_stepCnt;
   logic [`UPCD_LAMP_N-1:0]  lamps_ff;
   logic [`UPCD_LAMP_N-1:0]  nxt_lamps;
   logic                     stepTick;

   assign stepTick = (stepCnt_ff == CNT_W'(STEP_CYCLES - 1));

   // Runs whenever clkEn is high: nothing from the checker reaches here, so repair never stalls it
   always_comb begin
      nxt_stepCnt = stepCnt_ff + CNT_W'(1);
      nxt_lamps   = lamps_ff;
      if (stepTick) begin
         nxt_stepCnt = '0;
         nxt_lamps   = {lamps_ff[0], lamps_ff[`UPCD_LAMP_N-1:1]};
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         stepCnt_ff <= '0;
         lamps_ff   <= `UPCD_LAMP_RST;
      end else if (clkEn) begin
         stepCnt_ff <= nxt_stepCnt;
         lamps_ff   <= nxt_lamps;
      end
   end

   assign lamps = lamps_ff;

   property p_lamp_onehot;
      @(posedge clk) disable iff (!rstN) $onehot(lamps_ff);
   endproperty
   a_lamp_onehot: assert property (p_lamp_onehot)
      else $error("Chase lamps not one-hot");

   property p_lamp_rotate;
      @(posedge clk) disable iff (!rstN)
         (stepTick && clkEn) |=> (lamps_ff == {$past(lamps_ff[0]), $past(lamps_ff[`UPCD_LAMP_N-1:1])});
   endproperty
   a_lamp_rotate: assert property (p_lamp_rotate)
      else $error("Chase lamp did not step toward D3");

   property p_lamp_hold;
      @(posedge clk) disable iff (!rstN)
         !(stepTick && clkEn) |=> $stable(lamps_ff);
   endproperty
   a_lamp_hold: assert property (p_lamp_hold)
      else $error("Chase lamp moved between steps");

endmodule // upcd_chase

// ===== upcd_demo_top.sv
// What this block does
// - Board reset clears all state asynchronously, except the chase lamps, which restart at D9.
// - First switch enables the upset checker.
// - Second switch starts one checker pass.
// - Seven lamps rotate one-hot, D9 to D3.
// - Rotation continues during memory repair.
// - Checker reads memory and detects errors.
// - Clean pass keeps error lamp off.
// - Dropping switches keeps clean indication.
// - Pass finding upset lights error lamp.
// - Error lamp stays lit after switches drop.
// - Clean pass after refresh clears lamp.
`timescale 1ns/1ps
`include "upcd_demo_regs.svh"

module upcd_demo_top #(
   parameter int unsigned STEP_CYCLES = `UPCD_STEP_CYCLES
) (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic                    clkEn,
   input  wire logic [1:0]              switchInputs,
   input  upcd_pkg::upcd_chk_rsp_s      chkRsp,
   output upcd_pkg::upcd_chk_req_s      chkReq,
   output logic [`UPCD_LAMP_N-1:0]      chaseLamps,
   output logic                         errorLamp,
   output logic                         errorOut
);

   logic [1:0]                rstPipe_ff;
   logic                      rstN;
   logic [1:0]                swMeta_ff;
   logic [1:0]                swSync_ff;
   logic                      startPrev_ff;
   logic [1:0]                nxt_swMeta;
   logic [1:0]                nxt_swSync;
   logic                      nxt_startPrev;
   logic                      enSync;
   logic                      startSync;
   logic                      startRise;
   upcd_pkg::upcd_state_e     state_ff;
   upcd_pkg::upcd_state_e     nxt_state;
   logic                      errFlag_ff;
   logic                      nxt_errFlag;
   logic                      passDone;

   // Reset release synchroniser; runs regardless of clkEn so reset always leaves
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstPipe_ff <= 2'h0;
      end else begin
         rstPipe_ff <= {rstPipe_ff[0], 1'h1};
      end
   end

   assign rstN = rstPipe_ff[1];

   // Switch synchronisers: the meta stage feeds only the sync stage
   always_comb begin
      nxt_swMeta    = switchInputs;
      nxt_swSync    = swMeta_ff;
      nxt_startPrev = swSync_ff[`UPCD_SW_START];
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         swMeta_ff    <= 2'h0;
         swSync_ff    <= 2'h0;
         startPrev_ff <= 1'h0;
      end else if (clkEn) begin
         swMeta_ff    <= nxt_swMeta;
         swSync_ff    <= nxt_swSync;
         startPrev_ff <= nxt_startPrev;
      end
   end

   assign enSync    = swSync_ff[`UPCD_SW_ENABLE];
   assign startSync = swSync_ff[`UPCD_SW_START];
   // Only an edge launches; a start held high gives one pass, not a stream
   assign startRise = startSync && !startPrev_ff;

   // Pass sequencer; enable dropping aborts without touching the indication
   always_comb begin
      nxt_state   = state_ff;
      nxt_errFlag = errFlag_ff;
      passDone    = 1'h0;
      case (state_ff)
         upcd_pkg::UPCD_IDLE: begin
            // Start without enable is ignored, the operator must enable first
            if (enSync && startRise) begin
               nxt_state = upcd_pkg::UPCD_LAUNCH;
            end
         end
         upcd_pkg::UPCD_LAUNCH: begin
            if (!enSync) begin
               nxt_state = upcd_pkg::UPCD_IDLE;
            end else begin
               nxt_state = upcd_pkg::UPCD_WAIT;
            end
         end
         upcd_pkg::UPCD_WAIT: begin
            if (!enSync) begin
               nxt_state = upcd_pkg::UPCD_IDLE;
            end else if (chkRsp.done) begin
               nxt_state   = upcd_pkg::UPCD_IDLE;
               passDone    = 1'h1;
               // Clean pass clears, upset sets; only a finished pass decides
               nxt_errFlag = chkRsp.err;
            end
         end
         default: begin
            nxt_state = upcd_pkg::UPCD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_ff   <= upcd_pkg::UPCD_IDLE;
         errFlag_ff <= `UPCD_ERR_RST;
      end else if (clkEn) begin
         state_ff   <= nxt_state;
         // Held otherwise, so switches going low leave the lamp as it is
         errFlag_ff <= nxt_errFlag;
      end
   end

   assign chkReq.enable = enSync;
   // Gated so an enable dropped in the launch cycle never pulses start alone
   assign chkReq.start  = (state_ff == upcd_pkg::UPCD_LAUNCH) && enSync;
   assign errorLamp     = errFlag_ff;
   assign errorOut      = errFlag_ff;

   upcd_chase #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_chase (
      .clk   (clk),
      .rstN  (rstN),
      .clkEn (clkEn),
      .lamps (chaseLamps)
   );

   sequence s_launch;
      (state_ff == upcd_pkg::UPCD_LAUNCH) && chkReq.start && chkReq.enable;
   endsequence

   sequence s_request;
      (state_ff == upcd_pkg::UPCD_IDLE) && enSync && startRise && clkEn;
   endsequence

   property p_reset_clears;
      @(posedge clk) !rstN |-> (!errorLamp && !errorOut && !chkReq.start
                                && state_ff == upcd_pkg::UPCD_IDLE);
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("State not cleared under reset");

   property p_start_launch;
      @(posedge clk) disable iff (!rstN) s_request |=> s_launch;
   endproperty
   a_start_launch: assert property (p_start_launch)
      else $error("Start edge did not launch a pass");

   property p_enable_gates;
      @(posedge clk) disable iff (!rstN)
         !enSync |-> !chkReq.start && !chkReq.enable;
   endproperty
   a_enable_gates: assert property (p_enable_gates)
      else $error("Checker driven while enable is low");

   property p_no_start_without_en;
      @(posedge clk) disable iff (!rstN)
         ((state_ff == upcd_pkg::UPCD_IDLE) && !enSync && clkEn) |=> !chkReq.start;
   endproperty
   a_no_start_without_en: assert property (p_no_start_without_en)
      else $error("Pass launched without enable");

   property p_launch_then_wait;
      @(posedge clk) disable iff (!rstN)
         (s_launch and (enSync && clkEn)) |=> (state_ff == upcd_pkg::UPCD_WAIT) && !chkReq.start;
   endproperty
   a_launch_then_wait: assert property (p_launch_then_wait)
      else $error("Start pulse not one cycle then wait");

   property p_clean_pass_off;
      @(posedge clk) disable iff (!rstN)
         (passDone && clkEn && !chkRsp.err) |=> !errorLamp && !errorOut;
   endproperty
   a_clean_pass_off: assert property (p_clean_pass_off)
      else $error("Clean pass left error lamp lit");

   property p_upset_lights;
      @(posedge clk) disable iff (!rstN)
         (passDone && clkEn && chkRsp.err) |=> errorLamp && errorOut;
   endproperty
   a_upset_lights: assert property (p_upset_lights)
      else $error("Upset pass did not light error lamp");

   property p_hold_between_passes;
      @(posedge clk) disable iff (!rstN)
         !(passDone && clkEn) |=> $stable(errorLamp);
   endproperty
   a_hold_between_passes: assert property (p_hold_between_passes)
      else $error("Error lamp changed without a finished pass");

   property p_switch_drop_keeps;
      @(posedge clk) disable iff (!rstN)
         ($fell(enSync) && !errorLamp) |=> !errorLamp [*3];
   endproperty
   a_switch_drop_keeps: assert property (p_switch_drop_keeps)
      else $error("Dropping switches lit the error lamp");

   property p_refresh_clears;
      @(posedge clk) disable iff (!rstN)
         (errorLamp && passDone && clkEn && !chkRsp.err) |=> $fell(errorLamp);
   endproperty
   a_refresh_clears: assert property (p_refresh_clears)
      else $error("Clean pass did not clear flagged lamp");

   property p_sync_latency;
      @(posedge clk) disable iff (!rstN)
         clkEn |=> (swSync_ff == $past(swMeta_ff));
   endproperty
   a_sync_latency: assert property (p_sync_latency)
      else $error("Switch synchroniser skipped a stage");

   property p_outputs_match;
      @(posedge clk) disable iff (!rstN) errorOut == errorLamp;
   endproperty
   a_outputs_match: assert property (p_outputs_match)
      else $error("Error output and lamp disagree");

endmodule // upcd_demo_top

// ===== upcd_chk_model.sv
`timescale 1ns/1ps

module upcd_chk_model (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  upcd_pkg::upcd_chk_req_s      chkReq,
   input  wire logic                    injectErr,
   input  wire logic [3:0]              latency,
   output upcd_pkg::upcd_chk_rsp_s      chkRsp
);
   logic       busy;
   logic [3:0] cnt;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy   <= 1'b0;
         cnt    <= 4'h0;
         chkRsp <= '0;
      end else begin
         chkRsp.done <= 1'b0;
         // Error flag is junk outside done, so it toggles on every cycle that does not raise done
         chkRsp.err  <= ~chkRsp.err;
         if (!chkReq.enable) begin
            busy <= 1'b0;
         end else if (chkReq.start) begin
            busy <= 1'b1;
            cnt  <= latency;
         end else if (busy && cnt == 4'h0) begin
            busy        <= 1'b0;
            chkRsp.done <= 1'b1;
            chkRsp.err  <= injectErr;
         end else if (busy) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule // upcd_chk_model

// ===== test_upset_check_demo_logic.sv
`timescale 1ns/1ps

`define UPCD_CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module test_upset_check_demo_logic;
   localparam int STEP = 4;
   logic                    clk = 1'b0;
   logic                    nrst = 1'b1;
   logic                    clkEn = 1'b1;
   logic [1:0]              switchInputs = 2'b00;
   logic                    injectErr = 1'b0;
   logic [3:0]              latency = 4'h2;
   upcd_pkg::upcd_chk_rsp_s chkRsp;
   upcd_pkg::upcd_chk_req_s chkReq;
   logic [6:0]              chaseLamps;
   logic                    errorLamp;
   logic                    errorOut;
   int                      n_errors = 0;
   int                      checks = 0;
   int                      nStart = 0;
   int                      cycles = 0;

   upcd_demo_top #(.STEP_CYCLES(STEP)) dut (.clk(clk), .nrst(nrst), .clkEn(clkEn),
      .switchInputs(switchInputs), .chkRsp(chkRsp), .chkReq(chkReq), .chaseLamps(chaseLamps),
      .errorLamp(errorLamp), .errorOut(errorOut));

   upcd_chk_model model (.clk(clk), .nrst(nrst), .chkReq(chkReq), .injectErr(injectErr),
      .latency(latency), .chkRsp(chkRsp));

   always #5 clk = ~clk;

   always @(posedge clk) begin
      if (chkReq.start === 1'b1) nStart++;
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chase_check();
      logic [6:0] exp;
      int         w;
      w = 0;
      @(posedge clk);
      #1;
      exp = chaseLamps;
      while (chaseLamps === exp && w < 20) begin
         @(posedge clk);
         #1;
         w++;
      end
      for (int i = 0; i < 8; i++) begin
         exp = {chaseLamps[0], chaseLamps[6:1]};
         repeat (STEP) @(posedge clk);
         #1;
         `UPCD_CHK(chaseLamps, exp)
      end
   endtask

   task automatic run_pass(input logic err, input logic [3:0] lat);
      int   s0;
      int   w;
      logic old;
      s0 = nStart;
      old = errorLamp;
      w = 0;
      @(posedge clk);
      injectErr <= err;
      latency <= lat;
      switchInputs <= 2'b01;
      repeat (3) @(posedge clk);
      switchInputs <= 2'b11;
      #1;
      while (chkRsp.done !== 1'b1 && w < 40) begin
         @(posedge clk);
         #1;
         w++;
      end
      `UPCD_CHK(chkReq.enable, 1'b1)
      `UPCD_CHK(errorLamp, old)
      @(posedge clk);
      #1;
      `UPCD_CHK(errorLamp, err)
      `UPCD_CHK(errorOut, err)
      repeat (8) @(posedge clk);
      `UPCD_CHK(nStart - s0, 1)
      switchInputs <= 2'b00;
      repeat (6) @(posedge clk);
      #1;
      `UPCD_CHK(chkReq.enable, 1'b0)
      `UPCD_CHK(errorLamp, err)
   endtask

   task automatic no_enable();
      int s0;
      s0 = nStart;
      @(posedge clk);
      switchInputs <= 2'b10;
      repeat (10) @(posedge clk);
      `UPCD_CHK(nStart - s0, 0)
      switchInputs <= 2'b00;
      repeat (4) @(posedge clk);
   endtask

   task automatic abort_pass();
      int s0;
      s0 = nStart;
      @(posedge clk);
      injectErr <= 1'b1;
      latency <= 4'hf;
      switchInputs <= 2'b01;
      repeat (3) @(posedge clk);
      switchInputs <= 2'b11;
      repeat (5) @(posedge clk);
      switchInputs <= 2'b00;
      repeat (30) @(posedge clk);
      #1;
      `UPCD_CHK(nStart - s0, 1)
      `UPCD_CHK(errorLamp, 1'b0)
      `UPCD_CHK(errorOut, 1'b0)
   endtask

   task automatic freeze_check();
      logic [6:0] held;
      @(posedge clk);
      clkEn <= 1'b0;
      @(posedge clk);
      #1;
      held = chaseLamps;
      repeat (3 * STEP) @(posedge clk);
      #1;
      `UPCD_CHK(chaseLamps, held)
      `UPCD_CHK(errorLamp, 1'b1)
      @(posedge clk);
      clkEn <= 1'b1;
      repeat (2) @(posedge clk);
   endtask

   task automatic mid_reset();
      @(posedge clk);
      nrst <= 1'b0;
      #1;
      `UPCD_CHK(errorLamp, 1'b0)
      `UPCD_CHK(chaseLamps, 7'h40)
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   initial begin
      // Falling edge at time zero so the async reset acts before the first clock
      nrst <= 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      #1;
      `UPCD_CHK(chaseLamps, 7'h40)
      `UPCD_CHK(chkReq, 2'b00)
      repeat (4) @(posedge clk);
      no_enable();
      run_pass(1'b0, 4'h1);
      fork
         chase_check();
         run_pass(1'b1, 4'h6);
      join
      run_pass(1'b0, 4'h0);
      abort_pass();
      run_pass(1'b1, 4'h0);
      freeze_check();
      mid_reset();
      run_pass(1'b0, 4'h2);
      test_done();
   end
endmodule // test_upset_check_demo_logic
